// [core/duc_core.sv]
// Calibration data path: channel registers, shared correction engine, latches.
// Assumes host write and read strobes are synchronous one-cycle requests.
`timescale 1ns/1ps
module duc_core
  import duc_pkg::*;
(
  input  wire logic                 sys_clk_in,            // System clock, 100 MHz
  input  wire logic                 reset_in,              // Synchronous reset, active high
  input  wire logic                 correction_enable_in,  // Correction engine enable
  input  wire logic                 wr_en_in,              // Register write strobe
  input  wire duc_wr_s              wr_in,                 // Write kind, channel, data
  input  wire logic                 rd_en_in,              // Register read strobe
  input  wire duc_rd_s              rd_in,                 // Read kind and channel
  output logic      [CODE_W-1:0]    rd_data_out,           // Read data
  output logic                      rd_valid_out,          // Read data valid pulse
  output duc_codes_t                latch_code_out,        // Converter latch codes
  output logic      [NUM_CH-1:0]    latch_upd_out,         // Latch reload pulse per channel
  output logic      [NUM_GROUP-1:0] group_busy_out,        // Correction work pending per group
  output logic                      engine_busy_out        // Engine not idle
);

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [NUM_GROUP-1:0] group_of(input logic [CH_W-1:0] ch);
    group_of = (ch < CH_W'(GROUP_SIZE)) ? NUM_GROUP'(1) : NUM_GROUP'(2);
  endfunction

  function automatic logic [CODE_W-1:0] sat_code(input logic signed [SUM_W-1:0] s);
    if (s < 0) begin
      sat_code = CODE_MIN;
    end else if (s > $signed({3'b000, CODE_MAX})) begin
      sat_code = CODE_MAX;
    end else begin
      sat_code = s[CODE_W-1:0];
    end
  endfunction

  // ****************************************
  // Write decode
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_CALC, ST_WRITE} duc_state_e;

  duc_state_e              state_q;
  duc_state_e              state_d;
  logic [CH_W-1:0]         chan_q;
  logic [CODE_W-1:0]       result_q;
  logic [NUM_CH-1:0]       pending_q;
  logic [NUM_CH-1:0]       pending_d;
  logic [CODE_W-1:0]       in_rd;
  logic [CODE_W-1:0]       gain_rd;
  logic [CODE_W-1:0]       zero_rd;
  logic [CODE_W-1:0]       in_host;
  logic [CODE_W-1:0]       gain_host;
  logic [CODE_W-1:0]       zero_host;
  logic [CODE_W-1:0]       data_host;
  duc_reg_e                rd_kind_q;
  logic                    rd_pend_q;

  wire                     wr_input  = wr_en_in && (wr_in.kind == REG_INPUT || wr_in.kind == REG_DATA);
  wire                     wr_gain   = wr_en_in && (wr_in.kind == REG_GAIN);
  wire                     wr_zero   = wr_en_in && (wr_in.kind == REG_ZERO);
  wire                     in_we     = wr_input && correction_enable_in;
  wire                     bypass_we = wr_input && !correction_enable_in;
  wire                     req_set   = correction_enable_in && (wr_input || wr_gain || wr_zero);
  wire [NUM_CH-1:0]        set_vec   = req_set ? (NUM_CH'(1) << wr_in.chan) : '0;
  wire                     eng_stall = (state_q == ST_WRITE) && bypass_we;
  wire                     eng_we    = (state_q == ST_WRITE) && !eng_stall;
  wire                     data_we   = bypass_we || eng_we;
  wire [CH_W-1:0]          data_ch   = bypass_we ? wr_in.chan : chan_q;
  wire [CODE_W-1:0]        data_val  = bypass_we ? wr_in.data : result_q;

  // ****************************************
  // Channel registers
  // ****************************************
  duc_regmem #(.RESET_VAL(INPUT_RESET)) u_input_mem (
    .sys_clk_in  (sys_clk_in),
    .reset_in    (reset_in),
    .we_in       (in_we),
    .waddr_in    (wr_in.chan),
    .wdata_in    (wr_in.data),
    .raddr_a_in  (rd_in.chan),
    .raddr_b_in  (chan_q),
    .rdata_a_out (in_host),
    .rdata_b_out (in_rd)
  );

  duc_regmem #(.RESET_VAL(GAIN_RESET)) u_gain_mem (
    .sys_clk_in  (sys_clk_in),
    .reset_in    (reset_in),
    .we_in       (wr_gain),
    .waddr_in    (wr_in.chan),
    .wdata_in    (wr_in.data),
    .raddr_a_in  (rd_in.chan),
    .raddr_b_in  (chan_q),
    .rdata_a_out (gain_host),
    .rdata_b_out (gain_rd)
  );

  duc_regmem #(.RESET_VAL(ZERO_RESET)) u_zero_mem (
    .sys_clk_in  (sys_clk_in),
    .reset_in    (reset_in),
    .we_in       (wr_zero),
    .waddr_in    (wr_in.chan),
    .wdata_in    (wr_in.data),
    .raddr_a_in  (rd_in.chan),
    .raddr_b_in  (chan_q),
    .rdata_a_out (zero_host),
    .rdata_b_out (zero_rd)
  );

  duc_regmem #(.RESET_VAL(DATA_RESET)) u_data_mem (
    .sys_clk_in  (sys_clk_in),
    .reset_in    (reset_in),
    .we_in       (data_we),
    .waddr_in    (data_ch),
    .wdata_in    (data_val),
    .raddr_a_in  (rd_in.chan),
    .raddr_b_in  (chan_q),
    .rdata_a_out (data_host),
    .rdata_b_out ()
  );

  // ****************************************
  // Host readback
  // ****************************************
  wire [CODE_W-1:0] rd_mux = (rd_kind_q == REG_INPUT) ? in_host :
                             (rd_kind_q == REG_GAIN)  ? gain_host :
                             (rd_kind_q == REG_ZERO)  ? zero_host : data_host;

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      rd_kind_q    <= REG_INPUT;
      rd_pend_q    <= 1'b0;
      rd_data_out  <= CODE_MIN;
      rd_valid_out <= 1'b0;
    end else begin
      rd_kind_q    <= rd_in.kind;
      rd_pend_q    <= rd_en_in;
      rd_valid_out <= rd_pend_q;
      if (rd_pend_q) begin
        rd_data_out <= rd_mux;
      end
    end
  end

  // ****************************************
  // Shared correction engine
  // ****************************************
  logic [CH_W-1:0] pick;
  always_comb begin
    pick = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (pending_q[i]) begin
        pick = CH_W'(i);
      end
    end
  end

  wire                           start     = (state_q == ST_IDLE) && correction_enable_in && (pending_q != '0);
  wire [NUM_CH-1:0]              clr_vec   = start ? (NUM_CH'(1) << pick) : '0;
  wire [GAIN_EFF_W-1:0]          gain_eff  = {1'b0, gain_rd} + GAIN_BIAS;
  wire [PROD_W-1:0]              prod      = PROD_W'(in_rd) * PROD_W'(gain_eff);
  wire [GAIN_EFF_W-1:0]          scaled    = GAIN_EFF_W'(prod >> PROD_SHIFT);
  wire signed [SUM_W-1:0]        zero_ext  = SUM_W'($signed(zero_rd));
  wire signed [SUM_W-1:0]        sum_w     = $signed({2'b00, scaled}) + zero_ext;

  // Queue: a new request wins over the clear of the same bit
  assign pending_d = correction_enable_in ? ((pending_q & ~clr_vec) | set_vec) : '0;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:  state_d = start ? ST_READ : ST_IDLE;
      ST_READ:  state_d = ST_CALC;
      ST_CALC:  state_d = ST_WRITE;
      ST_WRITE: state_d = eng_stall ? ST_WRITE : ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      state_q   <= ST_IDLE;
      pending_q <= '0;
      chan_q    <= '0;
      result_q  <= CODE_MIN;
    end else begin
      state_q   <= state_d;
      pending_q <= pending_d;
      if (start) begin
        chan_q <= pick;
      end
      if (state_q == ST_CALC) begin
        result_q <= sat_code(sum_w);
      end
    end
  end

  // ****************************************
  // Converter latches and group status
  // ****************************************
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      latch_code_out <= {NUM_CH{DATA_RESET}};
      latch_upd_out  <= '0;
    end else begin
      latch_upd_out <= data_we ? (NUM_CH'(1) << data_ch) : '0;
      if (data_we) begin
        latch_code_out[data_ch] <= data_val;
      end
    end
  end

  wire [NUM_GROUP-1:0] active_grp = (state_q != ST_IDLE) ? group_of(chan_q) : '0;
  assign group_busy_out  = active_grp | {(|pending_q[NUM_CH-1:GROUP_SIZE]), (|pending_q[GROUP_SIZE-1:0])};
  assign engine_busy_out = (state_q != ST_IDLE);

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  AST_BYPASS_PASS: assert property (
    bypass_we |=> latch_code_out[$past(wr_in.chan)] == $past(wr_in.data) && latch_upd_out[$past(wr_in.chan)])
    else $error("bypass write did not reach the latch unmodified");

  AST_TRIM_NO_CALC: assert property (
    !correction_enable_in && state_q == ST_IDLE |=> state_q == ST_IDLE && pending_q == '0)
    else $error("calculation started while correction disabled");

  AST_QUEUE_SET: assert property (
    req_set |=> pending_q[$past(wr_in.chan)] || !correction_enable_in)
    else $error("enabled write did not queue a recalculation");

  AST_ENGINE_SEQ: assert property (
    state_q == ST_READ |=> state_q == ST_CALC ##1 state_q == ST_WRITE)
    else $error("engine sequence broken");

  AST_WRITE_BOUND: assert property (
    start |-> ##[3:8] latch_upd_out[chan_q])
    else $error("queued request not delivered to latch in time");

  AST_RESULT_STORE: assert property (
    eng_we |=> latch_code_out[$past(chan_q)] == $past(result_q))
    else $error("engine result not stored");

  AST_UNITY: assert property (
    state_q == ST_CALC && gain_rd == GAIN_RESET && zero_rd == ZERO_RESET |=> result_q == $past(in_rd))
    else $error("unity trim changed the code");

  AST_SAT_HIGH: assert property (
    state_q == ST_CALC && sum_w > $signed({3'b000, CODE_MAX}) |=> result_q == CODE_MAX)
    else $error("overflow did not saturate high");

  AST_SAT_LOW: assert property (
    state_q == ST_CALC && sum_w < 0 |=> result_q == CODE_MIN)
    else $error("underflow did not saturate low");

  AST_READBACK: assert property (
    (wr_gain ##1 (rd_en_in && !wr_en_in && rd_in.kind == REG_GAIN && rd_in.chan == $past(wr_in.chan)))
      |-> ##2 rd_valid_out && rd_data_out == $past(wr_in.data, 3))
    else $error("gain trim readback mismatch");

  COV_BYPASS: cover property (bypass_we);
  COV_CORRECT: cover property (eng_we && result_q != in_rd);
  COV_QUEUED: cover property (start && ($countones(pending_q) > 1));
  COV_STALL: cover property (eng_stall);

endmodule

// [pkg/duc_pkg.sv]
// Shared types and constants for the user calibration data path.
// Assumes one synchronous clock domain; imported whole by every design module.
package duc_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int CODE_W     = 16;
  localparam int NUM_CH     = 8;
  localparam int CH_W       = 3;
  localparam int GROUP_SIZE = 4;
  localparam int NUM_GROUP  = 2;
  localparam int GAIN_EFF_W = CODE_W + 1;
  localparam int PROD_W     = CODE_W + GAIN_EFF_W;
  localparam int SUM_W      = CODE_W + 3;

  // ****************************************
  // Reset values and arithmetic constants
  // ****************************************
  localparam logic [CODE_W-1:0]     INPUT_RESET = 16'h0000;
  localparam logic [CODE_W-1:0]     GAIN_RESET  = 16'h8000;
  localparam logic [CODE_W-1:0]     ZERO_RESET  = 16'h0000;
  localparam logic [CODE_W-1:0]     DATA_RESET  = 16'h0000;
  localparam logic [CODE_W-1:0]     CODE_MAX    = 16'hFFFF;
  localparam logic [CODE_W-1:0]     CODE_MIN    = 16'h0000;
  localparam logic [GAIN_EFF_W-1:0] GAIN_BIAS   = 17'h08000;
  localparam int                    PROD_SHIFT  = 16;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {REG_INPUT, REG_GAIN, REG_ZERO, REG_DATA} duc_reg_e;

  typedef struct packed {
    duc_reg_e               kind;
    logic [CH_W-1:0]        chan;
    logic [CODE_W-1:0]      data;
  } duc_wr_s;

  typedef struct packed {
    duc_reg_e               kind;
    logic [CH_W-1:0]        chan;
  } duc_rd_s;

  typedef logic [NUM_CH-1:0][CODE_W-1:0] duc_codes_t;

endpackage

// [core/duc_regmem.sv]
// Eight-word register memory, one write port, two registered read ports.
// Assumes a synchronous active-high reset that loads every word with RESET_VAL.
`timescale 1ns/1ps
module duc_regmem
  import duc_pkg::*;
#(
  parameter logic [CODE_W-1:0] RESET_VAL = 16'h0000
) (
  input  wire logic              sys_clk_in,  // System clock
  input  wire logic              reset_in,    // Synchronous reset
  input  wire logic              we_in,       // Write enable
  input  wire logic [CH_W-1:0]   waddr_in,    // Write channel
  input  wire logic [CODE_W-1:0] wdata_in,    // Write data
  input  wire logic [CH_W-1:0]   raddr_a_in,  // Read channel, port A
  input  wire logic [CH_W-1:0]   raddr_b_in,  // Read channel, port B
  output logic      [CODE_W-1:0] rdata_a_out, // Registered data, port A
  output logic      [CODE_W-1:0] rdata_b_out  // Registered data, port B
);

  logic [NUM_CH-1:0][CODE_W-1:0] mem_q;

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      mem_q <= {NUM_CH{RESET_VAL}};
    end else if (we_in) begin
      mem_q[waddr_in] <= wdata_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      rdata_a_out <= RESET_VAL;
      rdata_b_out <= RESET_VAL;
    end else begin
      rdata_a_out <= mem_q[raddr_a_in];
      rdata_b_out <= mem_q[raddr_b_in];
    end
  end

endmodule

// [test/duc_host_model.sv]
// Host model: issues register writes, reads and the correction enable level.
// Assumes the bench calls its tasks after reset; it drives on rising edges only.
`timescale 1ns/1ps
module duc_host_model
  import duc_pkg::*;
(
  input  wire logic sys_clk_in,  // System clock
  output logic      en_out,      // Correction enable level
  output logic      wr_en_out,   // Write strobe
  output duc_wr_s   wr_out,      // Write request
  output logic      rd_en_out,   // Read strobe
  output duc_rd_s   rd_out       // Read request
);
  initial begin
    en_out    = 1'b0;
    wr_en_out = 1'b0;
    wr_out    = '0;
    rd_en_out = 1'b0;
    rd_out    = '0;
  end

  task automatic wr_reg(input duc_reg_e k, input logic [CH_W-1:0] ch, input logic [CODE_W-1:0] d);
    @(posedge sys_clk_in);
    wr_en_out <= 1'b1;
    wr_out    <= '{kind: k, chan: ch, data: d};
    rd_en_out <= 1'b0;
    rd_out    <= ~rd_out;
  endtask

  task automatic rd_reg(input duc_reg_e k, input logic [CH_W-1:0] ch);
    @(posedge sys_clk_in);
    rd_en_out <= 1'b1;
    rd_out    <= '{kind: k, chan: ch};
    wr_en_out <= 1'b0;
    wr_out    <= ~wr_out;
  endtask

  // Released bus shows a changing pattern, never the last value
  task automatic idle(input logic en);
    @(posedge sys_clk_in);
    wr_en_out <= 1'b0;
    rd_en_out <= 1'b0;
    wr_out    <= ~wr_out;
    rd_out    <= ~rd_out;
    en_out    <= en;
  endtask
endmodule

// [test/duc_core_test.sv]
// Self-checking bench for the calibration core with a host model in front.
// Assumes expected codes come from the bench's own arithmetic model.
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin miscompares++; $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module duc_core_test;
  import duc_pkg::*;
  logic                 sys_clk_in;
  logic                 reset_in;
  logic                 en;
  logic                 wr_en;
  duc_wr_s              wr;
  logic                 rd_en;
  duc_rd_s              rd;
  logic [CODE_W-1:0]    rd_data_out;
  logic                 rd_valid_out;
  duc_codes_t           latch_code_out;
  logic [NUM_CH-1:0]    latch_upd_out;
  logic [NUM_GROUP-1:0] group_busy_out;
  logic                 engine_busy_out;
  logic [CODE_W-1:0]    m_inp[NUM_CH], m_gain[NUM_CH], m_zero[NUM_CH], m_dat[NUM_CH];
  logic [CODE_W-1:0]    exp_lat[NUM_CH][$], exp_rd[$], e, r;
  int                   compares, miscompares, cycles, seed;
  logic                 en_mode;

  duc_host_model duc_host_model_inst (.sys_clk_in(sys_clk_in), .en_out(en), .wr_en_out(wr_en),
    .wr_out(wr), .rd_en_out(rd_en), .rd_out(rd));
  duc_core duc_core_inst (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .correction_enable_in(en),
    .wr_en_in(wr_en), .wr_in(wr), .rd_en_in(rd_en), .rd_in(rd), .rd_data_out(rd_data_out),
    .rd_valid_out(rd_valid_out), .latch_code_out(latch_code_out), .latch_upd_out(latch_upd_out),
    .group_busy_out(group_busy_out), .engine_busy_out(engine_busy_out));

  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  // ****************************************
  // Reference model and host helpers
  // ****************************************
  function automatic logic [CODE_W-1:0] corr(logic [CODE_W-1:0] x, g, z);
    longint p;
    p = ((longint'(x) * (longint'(g) + 32768)) >>> 16) + longint'($signed(z));
    if (p > 65535) p = 65535;
    if (p < 0) p = 0;
    return p[CODE_W-1:0];
  endfunction

  task automatic wrc(input duc_reg_e k, input int ch, input logic [CODE_W-1:0] d);
    duc_host_model_inst.wr_reg(k, ch[CH_W-1:0], d);
    if (k == REG_GAIN) m_gain[ch] = d;
    else if (k == REG_ZERO) m_zero[ch] = d;
    else if (en_mode) m_inp[ch] = d;
    if (en_mode) begin
      m_dat[ch] = corr(m_inp[ch], m_gain[ch], m_zero[ch]);
      exp_lat[ch].push_back(m_dat[ch]);
    end else if (k == REG_INPUT || k == REG_DATA) begin
      m_dat[ch] = d;
      exp_lat[ch].push_back(d);
    end
  endtask

  task automatic rdc(input duc_reg_e k, input int ch);
    duc_host_model_inst.rd_reg(k, ch[CH_W-1:0]);
    case (k)
      REG_GAIN:  exp_rd.push_back(m_gain[ch]);
      REG_ZERO:  exp_rd.push_back(m_zero[ch]);
      REG_INPUT: exp_rd.push_back(m_inp[ch]);
      default:   exp_rd.push_back(m_dat[ch]);
    endcase
  endtask

  task automatic settle();
    duc_host_model_inst.idle(en_mode);
    repeat (3) @(posedge sys_clk_in);
    for (int i = 0; i < 200 && (engine_busy_out !== 1'b0 || group_busy_out !== 2'b00); i++)
      @(posedge sys_clk_in);
    repeat (3) @(posedge sys_clk_in);
  endtask

  task automatic test_done();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ****************************************
  // Output watcher and timeout
  // ****************************************
  always begin
    @(posedge sys_clk_in);
    #1;
    if (rd_valid_out === 1'b1) begin
      if (exp_rd.size() == 0) begin miscompares++; $display("ERROR %0t: unexpected read", $time); end
      else begin r = exp_rd.pop_front(); `CHK(rd_data_out, r) end
    end
    for (int c = 0; c < NUM_CH; c++)
      if (latch_upd_out[c] === 1'b1) begin
        if (exp_lat[c].size() == 0) begin miscompares++; $display("ERROR %0t: unexpected update", $time); end
        else begin e = exp_lat[c].pop_front(); `CHK(latch_code_out[c], e) end
      end
  end

  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      test_done();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 26829;
    en_mode = 1'b0;
    reset_in = 1'b1;
    for (int c = 0; c < NUM_CH; c++) begin
      m_inp[c] = 16'h0000; m_gain[c] = 16'h8000; m_zero[c] = 16'h0000; m_dat[c] = 16'h0000;
    end
    repeat (10) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    `CHK(latch_code_out, duc_codes_t'(0))
    for (int c = 0; c < NUM_CH; c++) begin
      rdc(REG_GAIN, c);
      rdc(REG_ZERO, c);
      rdc(REG_INPUT, c);
    end
    for (int c = 0; c < NUM_CH; c++) begin
      wrc(REG_INPUT, c, 16'($random(seed)));
      wrc(REG_GAIN, c, c == 0 ? 16'hFFFF : c == 1 ? 16'h0000 : c == 7 ? 16'h8000 : 16'($random(seed)));
      wrc(REG_ZERO, c, c == 0 ? 16'h7FFF : c == 1 ? 16'h8000 : c == 7 ? 16'h0000 : 16'($random(seed)));
    end
    settle();
    for (int c = 0; c < NUM_CH; c++) begin
      rdc(REG_GAIN, c);
      rdc(REG_ZERO, c);
    end
    en_mode = 1'b1;
    settle();
    for (int c = 0; c < NUM_CH; c++)
      wrc(REG_INPUT, c, c == 0 ? 16'hFFFF : c == 1 ? 16'h0100 : 16'($random(seed)));
    settle();
    wrc(REG_INPUT, 5, 16'($random(seed)));
    duc_host_model_inst.idle(1'b1);
    #1 `CHK(group_busy_out, 2'b10)
    @(posedge sys_clk_in) #1 `CHK(engine_busy_out, 1'b1)
    settle();
    wrc(REG_GAIN, 5, 16'($random(seed)));
    wrc(REG_ZERO, 6, 16'($random(seed)));
    wrc(REG_DATA, 2, 16'($random(seed)));
    settle();
    for (int c = 0; c < NUM_CH; c++) begin
      rdc(REG_DATA, c);
      rdc(REG_INPUT, c);
    end
    en_mode = 1'b0;
    settle();
    wrc(REG_DATA, 4, 16'($random(seed)));
    wrc(REG_GAIN, 3, 16'($random(seed)));
    rdc(REG_GAIN, 3);
    settle();
    for (int c = 0; c < NUM_CH; c++)
      `CHK(exp_lat[c].size(), 0)
    `CHK(exp_rd.size(), 0)
    test_done();
  end
endmodule
